// file: include/twrs_regs.vh
`ifndef TWRS_REGS_VH
`define TWRS_REGS_VH

// Bus address answered by the two-wire port.
`define TWRS_DEV_ADDR       7'h11

// Register addresses seen on the two-wire port.
`define TWRS_WRITE_DATA     8'h01
`define TWRS_READ_BYTE      8'h7F
`define TWRS_READ_WORD      8'h80

// Field widths and positions.
`define TWRS_PRESS_W        3
`define TWRS_DIR_BIT        0

// Reset values.
`define TWRS_WRITE_DATA_RST 8'h00

// Direction flag values in bit 0 of the address byte.
`define TWRS_DIR_WRITE      1'b0
`define TWRS_DIR_READ       1'b1

`endif

// file: src/twrs_sync2.v
`timescale 1ns/1ps
// Two-flop synchroniser, one stage pair per bit.
module twrs_sync2 #(
    parameter WIDTH = 2
) (
    // Clock and reset.
    input  wire             clk_in,
    input  wire             rst_in,
    // Asynchronous levels in, synchronised levels out.
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;

    ////////////////////////////////////////////////////////////////
    // Each bit passes two flops; only the second flop reads the first.
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_reg;
            reg stable_reg;
            always @(posedge clk_in) begin
                if (rst_in) begin
                    meta_reg   <= 1'b1;
                    stable_reg <= 1'b1;
                end else begin
                    meta_reg   <= async_in[i];
                    stable_reg <= meta_reg;
                end
            end
            assign sync_out[i] = stable_reg;
        end
    endgenerate

endmodule

// file: src/twrs_slave.v
`timescale 1ns/1ps
`include "twrs_regs.vh"

module twrs_slave (
    // Clock and reset.
    input  wire        MCLK_IN,
    input  wire        SYS_RST_IN,
    // Factory port selection strap.
    input  wire        PORT_EN_IN,
    // Two-wire pins; the data line is open drain.
    input  wire        SCL_IN,
    input  wire        SDA_IN,
    output reg         SDA_OUT,
    output reg         SDA_OE_OUT,
    // Values presented to the master on reads.
    input  wire [2:0]  PRESS_BITS_IN,
    input  wire [15:0] READ_WORD_IN,
    // Register writes towards the rest of the device.
    output reg         REG_WR_STB_OUT,
    output reg  [7:0]  REG_ADDR_OUT,
    output reg  [7:0]  REG_WDATA_OUT,
    output reg         REG_BYTE_IDX_OUT,
    output reg  [7:0]  WRITE_DATA_OUT,
    // Status.
    output reg         BUSY_OUT
);

    localparam [3:0] ST_IDLE     = 4'h0;
    localparam [3:0] ST_DEV_ADDR = 4'h1;
    localparam [3:0] ST_DEV_ACK  = 4'h2;
    localparam [3:0] ST_REG_ADDR = 4'h3;
    localparam [3:0] ST_REG_ACK  = 4'h4;
    localparam [3:0] ST_WR_DATA  = 4'h5;
    localparam [3:0] ST_WR_ACK   = 4'h6;
    localparam [3:0] ST_RD_DATA  = 4'h7;
    localparam [3:0] ST_RD_ACK   = 4'h8;
    localparam [3:0] ST_IGNORE   = 4'h9;

    wire [2:0]  sync_w;
    wire        scl_s;
    wire        sda_s;
    wire        en_s;
    reg         scl_q_reg;
    reg         sda_q_reg;
    reg  [3:0]  state_reg,  state_next;
    reg  [2:0]  cnt_reg,    cnt_next;
    reg         full_reg,   full_next;
    reg         rose_reg,   rose_next;
    reg  [7:0]  shift_reg,  shift_next;
    reg  [15:0] tx_reg,     tx_next;
    reg         rw_reg,     rw_next;
    reg         nack_reg,   nack_next;
    reg         idx_reg,    idx_next;
    reg  [7:0]  addr_reg,   addr_next;
    reg  [7:0]  wdata_reg,  wdata_next;
    reg         oe_next;
    reg         stb_next;
    wire        scl_rise;
    wire        scl_fall;
    wire        start_ev;
    wire        stop_ev;
    reg  [15:0] rd_val;

    ////////////////////////////////////////////////////////////////
    // Pins are foreign to MCLK, so they pass two flops first. No filter
    // follows: a glitch that survives the flops counts as an edge.
    twrs_sync2 #(
        .WIDTH (3)
    ) u_sync (
        .clk_in   (MCLK_IN),
        .rst_in   (SYS_RST_IN),
        .async_in ({PORT_EN_IN, SDA_IN, SCL_IN}),
        .sync_out (sync_w)
    );

    assign scl_s = sync_w[0];
    assign sda_s = sync_w[1];
    assign en_s  = sync_w[2];

    // Edge and bus condition detection on the synchronised levels.
    assign scl_rise = scl_s & ~scl_q_reg;
    assign scl_fall = ~scl_s & scl_q_reg;
    assign start_ev = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
    assign stop_ev  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

    ////////////////////////////////////////////////////////////////
    // Read value selected by the register address, MSB byte first.
    always @* begin
        case (addr_reg)
            `TWRS_WRITE_DATA: rd_val = {wdata_reg, 8'h00};
            `TWRS_READ_BYTE:  rd_val = {5'h00, PRESS_BITS_IN, 8'h00};
            `TWRS_READ_WORD:  rd_val = READ_WORD_IN;
            default:          rd_val = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // Protocol engine. Bits are taken on clock rise and the data line
    // only changes on clock fall or when the strap goes low, so the master
    // never sees it move while the clock is high unless the strap drops.
    always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        full_next  = full_reg;
        rose_next  = rose_reg;
        shift_next = shift_reg;
        tx_next    = tx_reg;
        rw_next    = rw_reg;
        nack_next  = nack_reg;
        idx_next   = idx_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        oe_next    = SDA_OE_OUT;
        stb_next   = 1'b0;
        if (!en_s) begin
            state_next = ST_IDLE;
            oe_next    = 1'b0;
        end else if (start_ev) begin
            // A start or repeated start restarts address reception.
            state_next = ST_DEV_ADDR;
            cnt_next   = 3'h0;
            full_next  = 1'b0;
            oe_next    = 1'b0;
        end else if (stop_ev) begin
            state_next = ST_IDLE;
            oe_next    = 1'b0;
        end else if (scl_rise) begin
            rose_next = 1'b1;
            case (state_reg)
                ST_DEV_ADDR, ST_REG_ADDR, ST_WR_DATA: begin
                    shift_next = {shift_reg[6:0], sda_s};
                    cnt_next   = cnt_reg + 3'h1;
                    full_next  = (cnt_reg == 3'h7);
                end
                ST_RD_DATA: begin
                    cnt_next  = cnt_reg + 3'h1;
                    full_next = (cnt_reg == 3'h7);
                end
                ST_RD_ACK: begin
                    nack_next = sda_s;
                end
                ST_DEV_ACK, ST_REG_ACK, ST_WR_ACK: begin
                    // Our own acknowledge pulse has risen; the next fall ends it.
                    rose_next = 1'b1;
                end
                default: begin
                    rose_next = rose_reg;
                end
            endcase
        end else if (scl_fall) begin
            case (state_reg)
                ST_DEV_ADDR: begin
                    if (full_reg) begin
                        full_next = 1'b0;
                        rose_next = 1'b0;
                        if (shift_reg[7:1] == `TWRS_DEV_ADDR) begin
                            rw_next    = shift_reg[`TWRS_DIR_BIT];
                            oe_next    = 1'b1;
                            state_next = ST_DEV_ACK;
                        end else begin
                            state_next = ST_IGNORE;
                        end
                    end
                end
                ST_DEV_ACK: begin
                    if (rose_reg) begin
                        cnt_next = 3'h0;
                        if (rw_reg == `TWRS_DIR_READ) begin
                            // Snapshot the value so it cannot tear mid byte.
                            tx_next    = rd_val;
                            oe_next    = ~rd_val[15];
                            state_next = ST_RD_DATA;
                        end else begin
                            oe_next    = 1'b0;
                            state_next = ST_REG_ADDR;
                        end
                    end
                end
                ST_REG_ADDR: begin
                    if (full_reg) begin
                        full_next  = 1'b0;
                        rose_next  = 1'b0;
                        addr_next  = shift_reg;
                        idx_next   = 1'b0;
                        oe_next    = 1'b1;
                        state_next = ST_REG_ACK;
                    end
                end
                ST_WR_DATA: begin
                    if (full_reg) begin
                        full_next  = 1'b0;
                        rose_next  = 1'b0;
                        stb_next   = 1'b1;
                        oe_next    = 1'b1;
                        state_next = ST_WR_ACK;
                        if (addr_reg == `TWRS_WRITE_DATA && !idx_reg) begin
                            wdata_next = shift_reg;
                        end
                    end
                end
                ST_REG_ACK, ST_WR_ACK: begin
                    if (rose_reg) begin
                        oe_next    = 1'b0;
                        cnt_next   = 3'h0;
                        state_next = ST_WR_DATA;
                        if (state_reg == ST_WR_ACK) begin
                            idx_next = ~idx_reg;
                        end
                    end
                end
                ST_RD_DATA: begin
                    tx_next = {tx_reg[14:0], 1'b0};
                    if (full_reg) begin
                        // Release the line for the master's answer.
                        full_next  = 1'b0;
                        rose_next  = 1'b0;
                        oe_next    = 1'b0;
                        state_next = ST_RD_ACK;
                    end else begin
                        oe_next = ~tx_reg[14];
                    end
                end
                ST_RD_ACK: begin
                    if (rose_reg) begin
                        cnt_next = 3'h0;
                        if (nack_reg) begin
                            state_next = ST_IGNORE;
                            oe_next    = 1'b0;
                        end else begin
                            state_next = ST_RD_DATA;
                            oe_next    = ~tx_reg[15];
                        end
                    end
                end
                default: begin
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // State and output flops. The data line output is held at zero, so
    // enabling it can only pull low.
    always @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            scl_q_reg        <= 1'b1;
            sda_q_reg        <= 1'b1;
            state_reg        <= ST_IDLE;
            cnt_reg          <= 3'h0;
            full_reg         <= 1'b0;
            rose_reg         <= 1'b0;
            shift_reg        <= 8'h00;
            tx_reg           <= 16'h0000;
            rw_reg           <= 1'b0;
            nack_reg         <= 1'b0;
            idx_reg          <= 1'b0;
            addr_reg         <= 8'h00;
            wdata_reg        <= `TWRS_WRITE_DATA_RST;
            SDA_OUT          <= 1'b0;
            SDA_OE_OUT       <= 1'b0;
            REG_WR_STB_OUT   <= 1'b0;
            REG_ADDR_OUT     <= 8'h00;
            REG_WDATA_OUT    <= 8'h00;
            REG_BYTE_IDX_OUT <= 1'b0;
            WRITE_DATA_OUT   <= `TWRS_WRITE_DATA_RST;
            BUSY_OUT         <= 1'b0;
        end else begin
            scl_q_reg        <= scl_s;
            sda_q_reg        <= sda_s;
            state_reg        <= state_next;
            cnt_reg          <= cnt_next;
            full_reg         <= full_next;
            rose_reg         <= rose_next;
            shift_reg        <= shift_next;
            tx_reg           <= tx_next;
            rw_reg           <= rw_next;
            nack_reg         <= nack_next;
            idx_reg          <= idx_next;
            addr_reg         <= addr_next;
            wdata_reg        <= wdata_next;
            SDA_OUT          <= 1'b0;
            SDA_OE_OUT       <= oe_next;
            REG_WR_STB_OUT   <= stb_next;
            REG_ADDR_OUT     <= addr_reg;
            REG_WDATA_OUT    <= shift_reg;
            REG_BYTE_IDX_OUT <= idx_reg;
            WRITE_DATA_OUT   <= wdata_next;
            BUSY_OUT         <= (state_next != ST_IDLE) && (state_next != ST_IGNORE);
        end
    end

endmodule

// file: tb/twrs_slave_assertions.sv
`timescale 1ns/1ps
`include "twrs_regs.vh"
// Watches the slave pins and its write outputs.
module twrs_slave_assertions (
    // Clock and reset.
    input wire       MCLK_IN,
    input wire       SYS_RST_IN,
    // Strap and pins.
    input wire       PORT_EN_IN,
    input wire       SCL_IN,
    input wire       SDA_IN,
    input wire       SDA_OUT,
    input wire       SDA_OE_OUT,
    // Write side and status.
    input wire       REG_WR_STB_OUT,
    input wire [7:0] REG_ADDR_OUT,
    input wire [7:0] REG_WDATA_OUT,
    input wire       REG_BYTE_IDX_OUT,
    input wire [7:0] WRITE_DATA_OUT,
    input wire       BUSY_OUT
);
    // Everything here runs on the system clock.
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    a_sda_low_only: assert property (SDA_OUT == 1'b0)
        else $error("data pin driven high");
    a_oe_scl_low: assert property ($changed(SDA_OE_OUT) |-> !SCL_IN)
        else $error("data pull changed while clock high");
    a_oe_stands: assert property ($rose(SDA_OE_OUT) |=> SDA_OE_OUT [*4])
        else $error("pull released too soon");
    a_strobe_single: assert property (REG_WR_STB_OUT |=> !REG_WR_STB_OUT)
        else $error("write strobe too long");
    a_strobe_acks: assert property (REG_WR_STB_OUT |-> ##[0:3] SDA_OE_OUT)
        else $error("written byte not acknowledged");
    a_store_first: assert property (
        REG_WR_STB_OUT && !REG_BYTE_IDX_OUT && REG_ADDR_OUT == `TWRS_WRITE_DATA
        |-> ##[0:1] WRITE_DATA_OUT == REG_WDATA_OUT)
        else $error("write_data not stored");
    a_store_cause: assert property (
        $changed(WRITE_DATA_OUT) |-> REG_WR_STB_OUT || $past(REG_WR_STB_OUT))
        else $error("write_data changed without a write");
    a_off_idle: assert property ((!PORT_EN_IN) [*6] |-> !BUSY_OUT && !SDA_OE_OUT)
        else $error("disabled port is active");
    a_stop_idle: assert property (
        SCL_IN && $rose(SDA_IN) |-> ##[1:6] !BUSY_OUT && !SDA_OE_OUT)
        else $error("stop did not free the port");
endmodule

bind twrs_slave twrs_slave_assertions twrs_slave_assertions_i (
    .MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN), .PORT_EN_IN(PORT_EN_IN),
    .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT),
    .REG_WR_STB_OUT(REG_WR_STB_OUT), .REG_ADDR_OUT(REG_ADDR_OUT),
    .REG_WDATA_OUT(REG_WDATA_OUT), .REG_BYTE_IDX_OUT(REG_BYTE_IDX_OUT),
    .WRITE_DATA_OUT(WRITE_DATA_OUT), .BUSY_OUT(BUSY_OUT)
);

// file: tb/twrs_host.sv
`timescale 1ns/1ps
// Bus master model: owns the serial clock and only pulls the data line low.
module twrs_host (
    // Clock and resolved data line.
    input  wire clk_in,
    input  wire sda_in,
    // Serial clock and data pull.
    output reg  scl_out,
    output reg  sda_low_out
);
    // Cycles per clock phase; raised by the bench to act as a slow master.
    integer phase = 8;
    // Bus idle: clock high, data released.
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    ////////////////////////////////////////
    // One clock phase of waiting.
    task half;
        repeat (phase) @(posedge clk_in);
    endtask
    // Start or repeated start; waits first so the data edge never meets a clock edge.
    task start;
        begin
            half;
            sda_low_out <= 1'b0;
            half;
            scl_out <= 1'b1;
            half;
            sda_low_out <= 1'b1;
            half;
            scl_out <= 1'b0;
        end
    endtask
    // Stop, then a free bus.
    task stop;
        begin
            half;
            sda_low_out <= 1'b1;
            half;
            scl_out <= 1'b1;
            half;
            sda_low_out <= 1'b0;
            half;
        end
    endtask
    // One byte and its acknowledge; data moves only while the clock is low.
    task byte_io(input [7:0] d, input ack, output [7:0] rd, output ack_seen);
        integer   i;
        reg [8:0] tx;
        reg [8:0] rx;
        begin
            tx = {d, ack};
            for (i = 8; i >= 0; i = i - 1) begin
                half;
                sda_low_out <= ~tx[i];
                half;
                scl_out <= 1'b1;
                half;
                rx[i] = sda_in;
                scl_out <= 1'b0;
            end
            rd = rx[8:1];
            ack_seen = rx[0];
        end
    endtask
endmodule

// file: tb/tb_twrs_slave.sv
`timescale 1ns/1ps
`include "twrs_regs.vh"
// Bench: the host model works the pins, tasks run whole transfers.
module tb_twrs_slave;
    localparam       LIMIT = 20000;
    localparam [7:0] WR_ADR = {`TWRS_DEV_ADDR, `TWRS_DIR_WRITE};
    localparam [7:0] RD_ADR = {`TWRS_DEV_ADDR, `TWRS_DIR_READ};
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         port_en = 1'b1;
    reg  [2:0]  press = 3'h0;
    reg  [15:0] word = 16'h0000;
    wire        scl, sda_low, sda_o, oe, stb, idx, busy;
    wire [7:0]  wr_a, wr_d, wdat;
    // Open-drain line with pull-up: released reads high.
    wire        sda = ~sda_low & (oe ? sda_o : 1'b1);
    integer     bad_count = 0;
    integer     checks = 0;
    integer     cycles = 0;
    integer     stb_n = 0;
    reg  [15:0] stb_data = 16'h0000;
    reg  [1:0]  stb_idx = 2'h0;
    reg  [7:0]  stb_addr = 8'h00;
    reg  [7:0]  rx;
    reg  [15:0] v;
    reg         ak;

    // Clock of 4 ns.
    always #2 clk = ~clk;

    twrs_slave twrs_slave_i (
        .MCLK_IN(clk), .SYS_RST_IN(rst), .PORT_EN_IN(port_en), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_o), .SDA_OE_OUT(oe), .PRESS_BITS_IN(press), .READ_WORD_IN(word),
        .REG_WR_STB_OUT(stb), .REG_ADDR_OUT(wr_a), .REG_WDATA_OUT(wr_d),
        .REG_BYTE_IDX_OUT(idx), .WRITE_DATA_OUT(wdat), .BUSY_OUT(busy)
    );
    twrs_host twrs_host_i (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));

    ////////////////////////////////////////
    // Logs write strobes and cuts a hung run short.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (stb === 1'b1) begin
            stb_n <= stb_n + 1;
            stb_data <= {stb_data[7:0], wr_d};
            stb_idx <= {stb_idx[0], idx};
            stb_addr <= wr_a;
        end
        if (cycles == LIMIT) begin
            bad_count = bad_count + 1;
            stop_test;
        end
    end
    // Counts a comparison and reports a mismatch.
    task chk(input [8*10-1:0] name, input [15:0] exp, input [15:0] got);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("unexpected %0s: expected %h, seen %h", name, exp, got);
            end
        end
    endtask
    // Prints the verdict and ends the run.
    task stop_test;
        begin
            if (bad_count == 0 && checks > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    // Start, write address and register address, each acknowledged.
    task addr_phase(input [7:0] reg_a);
        begin
            twrs_host_i.start;
            twrs_host_i.byte_io(WR_ADR, 1'b1, rx, ak);
            chk("dev ack", 16'h0, ak);
            twrs_host_i.byte_io(reg_a, 1'b1, rx, ak);
            chk("reg ack", 16'h0, ak);
        end
    endtask
    // Two-byte register write.
    task wr_reg(input [7:0] reg_a, input [15:0] d);
        begin
            addr_phase(reg_a);
            twrs_host_i.byte_io(d[15:8], 1'b1, rx, ak);
            chk("data1 ack", 16'h0, ak);
            twrs_host_i.byte_io(d[7:0], 1'b1, rx, ak);
            chk("data2 ack", 16'h0, ak);
            twrs_host_i.stop;
        end
    endtask
    // Read of one or two bytes; the master acks all but the last.
    task rd_reg(input [7:0] reg_a, input two, output [15:0] val);
        begin
            addr_phase(reg_a);
            twrs_host_i.start;
            twrs_host_i.byte_io(RD_ADR, 1'b1, rx, ak);
            chk("read ack", 16'h0, ak);
            twrs_host_i.byte_io(8'hFF, ~two, val[15:8], ak);
            val[7:0] = 8'h00;
            if (two) twrs_host_i.byte_io(8'hFF, 1'b1, val[7:0], ak);
            twrs_host_i.stop;
        end
    endtask

    ////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        chk("rst oe", 16'h0, oe);
        chk("rst wdata", 16'h0, wdat);
        wr_reg(`TWRS_WRITE_DATA, 16'hA55A);
        chk("stb count", 16'h2, stb_n);
        chk("stb data", 16'hA55A, stb_data);
        chk("stb idx", 16'h1, stb_idx);
        chk("stb addr", 16'h01, stb_addr);
        chk("wdata", 16'hA5, wdat);
        press <= 3'h5;
        word <= 16'hC3A6;
        rd_reg(`TWRS_READ_BYTE, 1'b0, v);
        chk("byte reg", 16'h0500, v);
        rd_reg(`TWRS_READ_WORD, 1'b1, v);
        chk("word reg", 16'hC3A6, v);
        rd_reg(`TWRS_WRITE_DATA, 1'b0, v);
        chk("readback", 16'hA500, v);
        // A word write elsewhere strobes both bytes and leaves write_data alone.
        wr_reg(`TWRS_READ_WORD, 16'h1234);
        chk("stb count2", 16'h4, stb_n);
        chk("stb data2", 16'h1234, stb_data);
        chk("stb addr2", 16'h80, stb_addr);
        chk("wdata kept", 16'hA5, wdat);
        // An unlisted register reads as zero in both bytes.
        rd_reg(8'h02, 1'b1, v);
        chk("other reg", 16'h0000, v);
        // A neighbouring address is refused; even our own address after it is ignored.
        twrs_host_i.start;
        twrs_host_i.byte_io({7'h10, `TWRS_DIR_WRITE}, 1'b1, rx, ak);
        chk("far nack", 16'h1, ak);
        twrs_host_i.byte_io(WR_ADR, 1'b1, rx, ak);
        chk("ignored", 16'h1, ak);
        chk("far busy", 16'h0, busy);
        twrs_host_i.stop;
        // With the strap low the port never answers.
        port_en <= 1'b0;
        twrs_host_i.start;
        twrs_host_i.byte_io(WR_ADR, 1'b1, rx, ak);
        chk("off nack", 16'h1, ak);
        twrs_host_i.stop;
        port_en <= 1'b1;
        // A slow master must get the same answers.
        twrs_host_i.phase = 20;
        word <= 16'h3C59;
        rd_reg(`TWRS_READ_WORD, 1'b1, v);
        chk("slow word", 16'h3C59, v);
        stop_test;
    end
endmodule
